// ===== design/pss_opbuf.v
// operand string store for compare and search
// assumes the caller clears it before each string and stops at the terminator
module pss_opbuf #(
	parameter DEPTH = 127
) (
	input  wire       clk_in,
	input  wire       arst_n_in,
	input  wire       clr_in,
	input  wire       wr_in,
	input  wire [7:0] wr_data_in,
	input  wire [6:0] rd_addr_in,
	output wire [7:0] rd_data_out,
	output reg  [6:0] cnt_out
);
	reg [7:0] mem [0:DEPTH-1];
	localparam [31:0] DEPTH_W = DEPTH;
	localparam [6:0]  LAST    = DEPTH_W[6:0];
	// ----------------------------------------------------------------
	// storage; characters past the cap are dropped (truncation)
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_out <= 7'h00;
		end else if (clr_in) begin
			cnt_out <= 7'h00;
		end else if (wr_in && cnt_out != LAST) begin
			cnt_out <= cnt_out + 7'h01;
		end
	end
	always @(posedge clk_in) begin
		if (wr_in && !clr_in && cnt_out != LAST) begin
			mem[cnt_out] <= wr_data_in;
		end
	end
	assign rd_data_out = (rd_addr_in < cnt_out) ? mem[rd_addr_in] : 8'h00;
endmodule

// ===== design/pss_regs.vh
// constants for the pointer, status and string-operation block
// assumes inclusion by bare name from every design file that needs them
`ifndef PSS_REGS_VH
`define PSS_REGS_VH
// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define PSS_OP_MAKE_PTR    8'h77
`define PSS_OP_HOLD_RD     8'hFD
`define PSS_OP_LOAD_STAT   8'hCD
`define PSS_OP_INS_BYTE    8'hED
`define PSS_OP_CMP_SEL     8'hE6
`define PSS_OP_STEP_BACK   8'hEF
`define PSS_OP_SET_SEPS    8'hE8
`define PSS_OP_SEL_FIELD   8'hE9
`define PSS_OP_SEARCH      8'hE7
// ----------------------------------------------------------------
// pointer kind byte and pointer layout
// ----------------------------------------------------------------
`define PSS_KIND_AUTOINC_BIT 7
`define PSS_KIND_CLASS_HI    5
`define PSS_KIND_CLASS_LO    3
`define PSS_CLASS_REG        3'h0
`define PSS_CLASS_DMA        3'h3
`define PSS_CLASS_FLASH      3'h5
`define PSS_KIND_DMA_FIRST   8'h18
`define PSS_KIND_DMA_LAST    8'h1F
`define PSS_KIND_FLASH_FIRST 8'h28
`define PSS_KIND_FLASH_LAST  8'h2F
`define PSS_PTR_TYPE_LSB     24
`define PSS_FLASH_FUNC_LSB   16
`define PSS_DEST_32          8'h00
`define PSS_DEST_64          8'h80
// ----------------------------------------------------------------
// status byte, separators, strings
// ----------------------------------------------------------------
`define PSS_STAT_RST       8'h00
`define PSS_STAT_LT_BIT    1
`define PSS_STAT_EQ_BIT    0
`define PSS_SEP_DEFAULT    8'h2C
`define PSS_SEP_MAX        6
`define PSS_OPSTR_MAX      127
`define PSS_FLD_IND_BIT    7
`define PSS_SBUF_MAX       255
`endif

// ===== design/pss_strbuf.v
// string buffer with single-cycle byte insertion and one read port
// assumes insert position is at most the current length
module pss_strbuf #(
	parameter DEPTH = 255
) (
	input  wire       clk_in,
	input  wire       arst_n_in,
	input  wire       ins_in,
	input  wire [7:0] ins_pos_in,
	input  wire [7:0] ins_data_in,
	input  wire [7:0] rd_addr_in,
	output wire [7:0] rd_data_out,
	output reg  [7:0] len_out
);
	reg [7:0] mem [0:DEPTH-1];
	localparam [31:0] DEPTH_W = DEPTH;
	localparam [7:0]  LAST    = DEPTH_W[7:0];
	integer i;
	// ----------------------------------------------------------------
	// insert shifts the tail up one place; a full buffer loses its last byte
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			len_out <= 8'h00;
		end else if (ins_in && len_out != LAST) begin
			len_out <= len_out + 8'h01;
		end
	end
	always @(posedge clk_in) begin
		for (i = DEPTH - 1; i >= 0; i = i - 1) begin
			if (ins_in && i > ins_pos_in) begin
				mem[i] <= mem[i-1];
			end else if (ins_in && i == ins_pos_in) begin
				mem[i] <= ins_data_in;
			end
		end
	end
	assign rd_data_out = (rd_addr_in < len_out) ? mem[rd_addr_in] : 8'h00;
endmodule

// ===== design/pss_top.v
// command interpreter for pointer, status, read-hold and string operations
// assumes opcode and operand bytes arrive on MCLK_IN from host-facing logic,
// and that the register file answers reads on the same clock
`include "pss_regs.vh"
module pss_top (
	input  wire        MCLK_IN,
	input  wire        ARST_N_IN,
	input  wire [7:0]  CMD_BYTE_IN,
	input  wire        CMD_VALID_IN,
	output reg         CMD_READY_OUT,
	input  wire        REGA_IS64_IN,
	output reg         REG_RD_REQ_OUT,
	output reg  [7:0]  REG_RD_ADDR_OUT,
	input  wire        REG_RD_VALID_IN,
	input  wire [7:0]  REG_RD_DATA_IN,
	output reg         PTR_WR_OUT,
	output reg  [7:0]  PTR_WR_ADDR_OUT,
	output reg  [63:0] PTR_WR_DATA_OUT,
	output reg  [7:0]  STATUS_OUT,
	output reg         READ_HOLD_OUT,
	input  wire        READ_DONE_IN,
	output reg  [7:0]  SEL_START_OUT,
	output reg  [7:0]  SEL_LEN_OUT,
	output wire [7:0]  STR_LEN_OUT
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_OPND  = 3'h1;
	localparam [2:0] S_STRG  = 3'h2;
	localparam [2:0] S_REGRD = 3'h3;
	localparam [2:0] S_CMP   = 3'h4;
	localparam [2:0] S_FIND  = 3'h5;
	localparam [2:0] S_FIELD = 3'h6;
	localparam integer SEP_N = `PSS_SEP_MAX;

	reg [2:0]  state_q;
	reg [7:0]  op_q;
	reg [1:0]  need_q;
	reg        kind_got_q;
	reg [7:0]  kind_q;
	reg [15:0] acc_q;
	reg [47:0] sep_q;
	reg [2:0]  sep_cnt_q;
	reg [7:0]  idx_q;
	reg [6:0]  jdx_q;
	reg [7:0]  fld_q;
	reg [7:0]  fstart_q;
	reg [7:0]  target_q;

	wire        take = CMD_VALID_IN & CMD_READY_OUT;
	wire [7:0]  sb_data;
	wire [7:0]  op_data;
	wire [6:0]  op_cnt;
	wire [7:0]  str_len;
	wire [31:0] ptr_val = {kind_q, acc_q, CMD_BYTE_IN};
	wire [2:0]  cls = CMD_BYTE_IN[`PSS_KIND_CLASS_HI:`PSS_KIND_CLASS_LO];
	wire        is_str_op = (CMD_BYTE_IN == `PSS_OP_CMP_SEL) || (CMD_BYTE_IN == `PSS_OP_SEARCH);
	wire        ins = (state_q == S_REGRD) && REG_RD_VALID_IN && (op_q == `PSS_OP_INS_BYTE);
	wire        op_clr = take && (state_q == S_IDLE) && is_str_op;
	wire        op_wr = take && (state_q == S_STRG) && (CMD_BYTE_IN != 8'h00) &&
		(op_q != `PSS_OP_SET_SEPS);
	wire [7:0]  find_addr = SEL_START_OUT + idx_q + {1'b0, jdx_q};
	wire [7:0]  cmp_addr = SEL_START_OUT + idx_q;
	wire [7:0]  sb_addr = (state_q == S_FIELD) ? idx_q :
		(state_q == S_FIND) ? find_addr : cmp_addr;
	wire [6:0]  op_addr = (state_q == S_FIND) ? jdx_q : idx_q[6:0];
	wire [8:0]  find_span = {1'b0, idx_q} + {2'b00, op_cnt};
	wire [7:0]  op_cnt8 = {1'b0, op_cnt};
	wire [7:0]  sel_end = SEL_START_OUT + SEL_LEN_OUT;

	assign STR_LEN_OUT = str_len;

	// ----------------------------------------------------------------
	// separator match, one comparator per slot
	// ----------------------------------------------------------------
	wire [`PSS_SEP_MAX-1:0] sep_hit;
	genvar g;
	generate
		for (g = 0; g < `PSS_SEP_MAX; g = g + 1) begin : gsep
			localparam integer GI = g;
			assign sep_hit[g] = ({29'h0, sep_cnt_q} > GI) && (sep_q[g*8 +: 8] == sb_data);
		end
	endgenerate
	wire at_end = (idx_q == str_len);
	wire is_sep = !at_end && (sep_hit != {`PSS_SEP_MAX{1'b0}});

	pss_strbuf #(
		.DEPTH (`PSS_SBUF_MAX)
	) u_sbuf (
		.clk_in      (MCLK_IN),
		.arst_n_in   (ARST_N_IN),
		.ins_in      (ins),
		.ins_pos_in  (SEL_START_OUT),
		.ins_data_in (REG_RD_DATA_IN),
		.rd_addr_in  (sb_addr),
		.rd_data_out (sb_data),
		.len_out     (str_len)
	);

	pss_opbuf #(
		.DEPTH (`PSS_OPSTR_MAX)
	) u_obuf (
		.clk_in      (MCLK_IN),
		.arst_n_in   (ARST_N_IN),
		.clr_in      (op_clr),
		.wr_in       (op_wr),
		.wr_data_in  (CMD_BYTE_IN),
		.rd_addr_in  (op_addr),
		.rd_data_out (op_data),
		.cnt_out     (op_cnt)
	);

	// ----------------------------------------------------------------
	// read hold: a new hold opcode wins over a read finishing together
	// ----------------------------------------------------------------
	always @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			READ_HOLD_OUT <= 1'b0;
		end else if (take && state_q == S_IDLE && CMD_BYTE_IN == `PSS_OP_HOLD_RD) begin
			READ_HOLD_OUT <= 1'b1;
		end else if (READ_DONE_IN) begin
			READ_HOLD_OUT <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state_q         <= S_IDLE;
			CMD_READY_OUT   <= 1'b0;
			op_q            <= 8'h00;
			need_q          <= 2'h0;
			kind_got_q      <= 1'b0;
			kind_q          <= 8'h00;
			acc_q           <= 16'h0000;
			sep_q           <= {40'h00_0000_0000, `PSS_SEP_DEFAULT};
			sep_cnt_q       <= 3'h1;
			idx_q           <= 8'h00;
			jdx_q           <= 7'h00;
			fld_q           <= 8'h00;
			fstart_q        <= 8'h00;
			target_q        <= 8'h00;
			REG_RD_REQ_OUT  <= 1'b0;
			REG_RD_ADDR_OUT <= 8'h00;
			PTR_WR_OUT      <= 1'b0;
			PTR_WR_ADDR_OUT <= 8'h00;
			PTR_WR_DATA_OUT <= {32'h0000_0000, 32'h0000_0000};
			STATUS_OUT      <= `PSS_STAT_RST;
			SEL_START_OUT   <= 8'h00;
			SEL_LEN_OUT     <= 8'h00;
		end else begin
			REG_RD_REQ_OUT <= 1'b0;
			PTR_WR_OUT     <= 1'b0;
			// ready rises one cycle after reset release
			if (state_q == S_IDLE) begin
				CMD_READY_OUT <= 1'b1;
			end
			case (state_q)
			S_IDLE: begin
				if (take) begin
					op_q       <= CMD_BYTE_IN;
					kind_got_q <= 1'b0;
					acc_q      <= 16'h0000;
					need_q     <= 2'h1;
					case (CMD_BYTE_IN)
					`PSS_OP_MAKE_PTR, `PSS_OP_LOAD_STAT, `PSS_OP_SEL_FIELD: begin
						state_q <= S_OPND;
					end
					`PSS_OP_CMP_SEL, `PSS_OP_SEARCH: begin
						state_q <= S_STRG;
					end
					`PSS_OP_SET_SEPS: begin
						sep_cnt_q <= 3'h0;
						state_q   <= S_STRG;
					end
					`PSS_OP_INS_BYTE: begin
						REG_RD_REQ_OUT  <= 1'b1;
						REG_RD_ADDR_OUT <= REGA_IS64_IN ? `PSS_DEST_64 : `PSS_DEST_32;
						CMD_READY_OUT   <= 1'b0;
						state_q         <= S_REGRD;
					end
					`PSS_OP_STEP_BACK: begin
						if (SEL_START_OUT != 8'h00) begin
							SEL_START_OUT <= SEL_START_OUT - 8'h01;
						end
						SEL_LEN_OUT <= 8'h00;
					end
					default: begin
						state_q <= S_IDLE;
					end
					endcase
				end
			end
			S_OPND: begin
				if (take) begin
					if (op_q == `PSS_OP_LOAD_STAT) begin
						STATUS_OUT <= CMD_BYTE_IN;
						state_q    <= S_IDLE;
					end else if (op_q == `PSS_OP_SEL_FIELD) begin
						if (CMD_BYTE_IN[`PSS_FLD_IND_BIT]) begin
							REG_RD_REQ_OUT  <= 1'b1;
							REG_RD_ADDR_OUT <= {1'b0, CMD_BYTE_IN[6:0]};
							state_q         <= S_REGRD;
						end else begin
							target_q <= {1'b0, CMD_BYTE_IN[6:0]};
							idx_q    <= 8'h00;
							fld_q    <= 8'h01;
							fstart_q <= 8'h00;
							state_q  <= S_FIELD;
						end
						CMD_READY_OUT <= 1'b0;
					end else if (!kind_got_q) begin
						kind_q     <= CMD_BYTE_IN;
						kind_got_q <= 1'b1;
						if (cls == `PSS_CLASS_FLASH) begin
							need_q <= 2'h3;
						end else if (cls == `PSS_CLASS_REG) begin
							need_q <= 2'h1;
						end else begin
							need_q <= 2'h2;
						end
					end else if (need_q == 2'h1) begin
						PTR_WR_OUT      <= 1'b1;
						PTR_WR_ADDR_OUT <= REGA_IS64_IN ? `PSS_DEST_64 : `PSS_DEST_32;
						PTR_WR_DATA_OUT <= {32'h0000_0000, ptr_val};
						state_q         <= S_IDLE;
					end else begin
						acc_q  <= {acc_q[7:0], CMD_BYTE_IN};
						need_q <= need_q - 2'h1;
					end
				end
			end
			S_STRG: begin
				if (take) begin
					if (op_q == `PSS_OP_SET_SEPS) begin
						if (CMD_BYTE_IN == 8'h00) begin
							if (sep_cnt_q == 3'h0) begin
								sep_q[7:0] <= `PSS_SEP_DEFAULT;
								sep_cnt_q  <= 3'h1;
							end
							state_q <= S_IDLE;
						end else if ({29'h0, sep_cnt_q} != SEP_N) begin
							sep_q[sep_cnt_q*8 +: 8] <= CMD_BYTE_IN;
							sep_cnt_q               <= sep_cnt_q + 3'h1;
						end
					end else if (CMD_BYTE_IN == 8'h00) begin
						idx_q         <= 8'h00;
						jdx_q         <= 7'h00;
						CMD_READY_OUT <= 1'b0;
						state_q       <= (op_q == `PSS_OP_CMP_SEL) ? S_CMP : S_FIND;
					end
				end
			end
			S_REGRD: begin
				if (REG_RD_VALID_IN) begin
					if (op_q == `PSS_OP_INS_BYTE) begin
						if (SEL_START_OUT != str_len || str_len != `PSS_SBUF_MAX) begin
							SEL_START_OUT <= SEL_START_OUT + 8'h01;
						end
						SEL_LEN_OUT <= 8'h00;
						state_q     <= S_IDLE;
					end else begin
						target_q <= REG_RD_DATA_IN;
						idx_q    <= 8'h00;
						fld_q    <= 8'h01;
						fstart_q <= 8'h00;
						state_q  <= S_FIELD;
					end
				end
			end
			S_CMP: begin
				// both strings are walked one character per cycle
				if (idx_q == SEL_LEN_OUT && idx_q == op_cnt8) begin
					STATUS_OUT <= 8'h01 << `PSS_STAT_EQ_BIT;
					state_q    <= S_IDLE;
				end else if (idx_q == SEL_LEN_OUT || (idx_q != op_cnt8 && sb_data < op_data)) begin
					STATUS_OUT <= 8'h01 << `PSS_STAT_LT_BIT;
					state_q    <= S_IDLE;
				end else if (idx_q == op_cnt8 || sb_data > op_data) begin
					STATUS_OUT <= 8'h00;
					state_q    <= S_IDLE;
				end else begin
					idx_q <= idx_q + 8'h01;
				end
			end
			S_FIND: begin
				// naive scan: cost grows with selection length times operand length
				if (op_cnt == 7'h00) begin
					SEL_LEN_OUT <= 8'h00;
					state_q     <= S_IDLE;
				end else if (find_span > {1'b0, SEL_LEN_OUT}) begin
					SEL_START_OUT <= sel_end;
					SEL_LEN_OUT   <= 8'h00;
					state_q       <= S_IDLE;
				end else if (sb_data == op_data) begin
					if (jdx_q == op_cnt - 7'h01) begin
						SEL_START_OUT <= SEL_START_OUT + idx_q;
						SEL_LEN_OUT   <= op_cnt8;
						state_q       <= S_IDLE;
					end else begin
						jdx_q <= jdx_q + 7'h01;
					end
				end else begin
					idx_q <= idx_q + 8'h01;
					jdx_q <= 7'h00;
				end
			end
			S_FIELD: begin
				if (target_q == 8'h00) begin
					SEL_START_OUT <= 8'h00;
					SEL_LEN_OUT   <= 8'h00;
					state_q       <= S_IDLE;
				end else if (fld_q == target_q && (at_end || is_sep)) begin
					SEL_START_OUT <= fstart_q;
					SEL_LEN_OUT   <= idx_q - fstart_q;
					state_q       <= S_IDLE;
				end else if (at_end) begin
					SEL_START_OUT <= str_len;
					SEL_LEN_OUT   <= 8'h00;
					state_q       <= S_IDLE;
				end else begin
					if (is_sep) begin
						fld_q    <= fld_q + 8'h01;
						fstart_q <= idx_q + 8'h01;
					end
					idx_q <= idx_q + 8'h01;
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// ===== verif/pointer_status_string_ops_test.sv
// self-checking bench: command bytes in, outputs against a queue model
// assumes pss_top and pss_reg_model compiled alongside
module pointer_status_string_ops_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_n, vld, is64, done, ready, rd_req, rd_vld, ptr_wr, hold;
	logic [7:0]  byte_in, rd_addr, rd_data, ptr_addr, status, ss_o, sl_o, len_o, kd, v;
	logic [63:0] ptr_data;
	logic [31:0] r, e;
	logic [3:0]  lat;
	logic [7:0]  sb[$];
	logic [7:0]  seps[$];
	int          ss, sl, st, seed, num_errors, cmp_count;
	string       s0, lng, cs[$];
	pss_top i_dut (.MCLK_IN(clk), .ARST_N_IN(rst_n), .CMD_BYTE_IN(byte_in),
		.CMD_VALID_IN(vld), .CMD_READY_OUT(ready), .REGA_IS64_IN(is64),
		.REG_RD_REQ_OUT(rd_req), .REG_RD_ADDR_OUT(rd_addr), .REG_RD_VALID_IN(rd_vld),
		.REG_RD_DATA_IN(rd_data), .PTR_WR_OUT(ptr_wr), .PTR_WR_ADDR_OUT(ptr_addr),
		.PTR_WR_DATA_OUT(ptr_data), .STATUS_OUT(status), .READ_HOLD_OUT(hold),
		.READ_DONE_IN(done), .SEL_START_OUT(ss_o), .SEL_LEN_OUT(sl_o),
		.STR_LEN_OUT(len_o));
	pss_reg_model i_part (.clk_in(clk), .arst_n_in(rst_n), .rd_req_in(rd_req),
		.rd_addr_in(rd_addr), .lat_in(lat), .wr_in(ptr_wr), .wr_addr_in(ptr_addr),
		.wr_data_in(ptr_data), .rd_valid_out(rd_vld), .rd_data_out(rd_data));
	// ------
	// checking and driving
	// ------
	task automatic end_sim();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic all_chk();
		chk("status", st, status);
		chk("sel_start", ss, ss_o);
		chk("sel_len", sl, sl_o);
		chk("str_len", sb.size(), len_o);
	endtask
	// bytes change at negedge; ready is registered so its negedge value is sampled
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(negedge clk);
			byte_in = q[i];
			vld = 1'b1;
			while (ready !== 1'b1) @(negedge clk);
		end
		@(negedge clk);
		vld = 1'b0;
		byte_in = ~byte_in;
		@(negedge clk);
		for (int k = 0; k < 2000 && ready !== 1'b1; k++) @(negedge clk);
		// a block that never comes back is a failure, not a silent skip
		if (ready !== 1'b1) begin
			num_errors++;
			end_sim();
		end
		@(negedge clk);
	endtask
	task automatic sop(input logic [7:0] opc, input string s);
		logic [7:0] q[$];
		q.push_back(opc);
		for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
		q.push_back(8'h00);
		send(q);
	endtask
	// ------
	// string model
	// ------
	task automatic ins(input logic [7:0] c);
		r = $random(seed);
		is64 = r[4];
		lat = 4'h1 + {2'b00, r[1:0]};
		send('{8'h77, 8'h00, c});
		send('{8'hED});
		if (sb.size() < 255) begin
			sb.insert(ss, c);
			ss++;
		end
		sl = 0;
		all_chk();
	endtask
	task automatic fld(input logic [7:0] b, input int f);
		int n;
		send('{8'hE9, b});
		n = 1;
		ss = 0;
		sl = 0;
		if (f != 0) begin
			for (int i = 0; i < sb.size() && n < f; i++)
				if (sb[i] inside {seps}) begin
					n++;
					ss = i + 1;
				end
			if (n < f)
				ss = sb.size();
			else
				for (int i = ss; i < sb.size() && !(sb[i] inside {seps}); i++) sl++;
		end
		all_chk();
	endtask
	function automatic int mcmp(string s);
		int n;
		n = (s.len() > 127) ? 127 : s.len();
		for (int i = 0; i < n && i < sl; i++)
			if (sb[ss + i] != s[i])
				return (sb[ss + i] < s[i]) ? 2 : 0;
		return (sl == n) ? 1 : (sl < n) ? 2 : 0;
	endfunction
	task automatic find(input string s);
		int n, k;
		sop(8'hE7, s);
		n = s.len();
		k = 0;
		for (int o = 0; n > 0 && o + n <= sl && k != n; o++) begin
			for (k = 0; k < n && sb[ss + o + k] == s[k]; k++);
			if (k == n) begin
				ss += o;
				sl = n;
			end
		end
		if (n == 0)
			sl = 0;
		else if (k != n) begin
			ss += sl;
			sl = 0;
		end
		all_chk();
	endtask
	// ------
	// stimulus
	// ------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		num_errors++;
		end_sim();
	end
	initial begin
		seed = 32'hb4ff;
		{rst_n, vld, is64, done, byte_in, lat} = '0;
		seps = '{8'h2C};
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		all_chk();
		repeat (4) begin
			v = $random(seed);
			send('{8'hCD, v});
			st = v;
			all_chk();
		end
		for (int k = 0; k < 18; k++) begin
			kd = (k < 8) ? 8'h18 + k : (k < 16) ? 8'h20 + k : (k == 16) ? 8'h01 : 8'h9C;
			r = $random(seed);
			is64 = r[31];
			if (kd[5:3] == 3'h0) begin
				send('{8'h77, kd, r[7:0]});
				e = {kd, 16'h0000, r[7:0]};
			end else if (kd[5:3] == 3'h5) begin
				send('{8'h77, kd, {2'b00, r[21:16]}, r[15:8], r[7:0]});
				e = {kd, 2'b00, r[21:16], r[15:0]};
			end else begin
				send('{8'h77, kd, r[15:8], r[7:0]});
				e = {kd, 8'h00, r[15:0]};
			end
			chk("ptr_data", {32'h0000_0000, e}, ptr_data);
			chk("ptr_dest", is64 ? 8'h80 : 8'h00, ptr_addr);
		end
		send('{8'hFD});
		repeat (3) @(negedge clk);
		chk("hold", 1, hold);
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
		chk("hold", 0, hold);
		s0 = "ab;cd,ef";
		for (int i = 0; i < s0.len(); i++) ins(s0[i]);
		fld(8'h02, 2);
		sop(8'hE8, ";,");
		seps = '{8'h3B, 8'h2C};
		all_chk();
		fld(8'h00, 0);
		fld(8'h03, 3);
		fld(8'h09, 9);
		i_part.mem[5] = 64'h0000_0000_0000_0002;
		fld(8'h85, 2);
		lng = "";
		repeat (130) lng = {lng, "c"};
		cs = '{"cd", "ce", "cc", "c", "cde", lng};
		foreach (cs[j]) begin
			sop(8'hE6, cs[j]);
			st = mcmp(cs[j]);
			all_chk();
		end
		fld(8'h01, 1);
		find("b");
		fld(8'h02, 2);
		find("x");
		fld(8'h02, 2);
		find("");
		fld(8'h00, 0);
		repeat (2) begin
			send('{8'hEF});
			if (ss > 0)
				ss--;
			sl = 0;
			all_chk();
			fld(8'h03, 3);
		end
		ins(8'h58);
		fld(8'h03, 3);
		end_sim();
	end
endmodule

// ===== verif/pss_reg_model.sv
// register file model: keeps pointer writes, answers byte reads
// assumes one read outstanding; lat_in of at least one
module pss_reg_model (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        rd_req_in,
	input  wire logic [7:0]  rd_addr_in,
	input  wire logic [3:0]  lat_in,
	input  wire logic        wr_in,
	input  wire logic [7:0]  wr_addr_in,
	input  wire logic [63:0] wr_data_in,
	output logic             rd_valid_out,
	output logic [7:0]       rd_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] mem [0:255];
	logic [7:0]  addr_q;
	int          wait_q;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wait_q <= 0;
			rd_valid_out <= 1'b0;
			rd_data_out <= 8'h00;
		end else begin
			rd_valid_out <= 1'b0;
			if (wr_in)
				mem[wr_addr_in] <= wr_data_in;
			if (rd_req_in) begin
				addr_q <= rd_addr_in;
				wait_q <= lat_in;
			end else if (wait_q > 0)
				wait_q <= wait_q - 1;
			if (wait_q == 1) begin
				rd_valid_out <= 1'b1;
				rd_data_out <= mem[addr_q][7:0];
			end else
				rd_data_out <= ~rd_data_out; // stale data never stands still
		end
	end
endmodule

// ===== verif/pss_top_assertions.sv
// checker for the pointer, status and string command interpreter
// assumes a bind onto pss_top; one clock domain
module pss_chk (
	input wire logic        MCLK_IN,
	input wire logic        ARST_N_IN,
	input wire logic        CMD_VALID_IN,
	input wire logic        CMD_READY_OUT,
	input wire logic        REGA_IS64_IN,
	input wire logic        REG_RD_REQ_OUT,
	input wire logic        PTR_WR_OUT,
	input wire logic [7:0]  PTR_WR_ADDR_OUT,
	input wire logic [63:0] PTR_WR_DATA_OUT,
	input wire logic [7:0]  STATUS_OUT,
	input wire logic        READ_HOLD_OUT,
	input wire logic        READ_DONE_IN,
	input wire logic [7:0]  SEL_START_OUT,
	input wire logic [7:0]  SEL_LEN_OUT,
	input wire logic [7:0]  STR_LEN_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	wire take = CMD_VALID_IN & CMD_READY_OUT;
	// ------
	// pointer writes
	// ------
	property p_ptr_dest;
		PTR_WR_OUT |-> PTR_WR_ADDR_OUT == ($past(REGA_IS64_IN) ? 8'h80 : 8'h00);
	endproperty
	a_ptr_dest: assert property (p_ptr_dest)
		else $error("pointer destination wrong");
	property p_ptr_hi;
		PTR_WR_OUT |-> PTR_WR_DATA_OUT[63:32] == 32'h0000_0000;
	endproperty
	a_ptr_hi: assert property (p_ptr_hi)
		else $error("pointer upper word not cleared");
	property p_ptr_pulse;
		PTR_WR_OUT |=> !PTR_WR_OUT;
	endproperty
	a_ptr_pulse: assert property (p_ptr_pulse)
		else $error("pointer write longer than one cycle");
	property p_ptr_reg;
		PTR_WR_OUT && PTR_WR_DATA_OUT[29:27] == 3'h0 |-> PTR_WR_DATA_OUT[23:8] == 16'h0000;
	endproperty
	a_ptr_reg: assert property (p_ptr_reg)
		else $error("register pointer address too wide");
	// ------
	// hold, reads, strings
	// ------
	property p_hold_keep;
		READ_HOLD_OUT && !READ_DONE_IN |=> READ_HOLD_OUT;
	endproperty
	a_hold_keep: assert property (p_hold_keep)
		else $error("hold dropped without read done");
	property p_hold_clr;
		READ_DONE_IN && !take |=> !READ_HOLD_OUT;
	endproperty
	a_hold_clr: assert property (p_hold_clr)
		else $error("hold not cleared by read done");
	property p_rd_busy;
		REG_RD_REQ_OUT |=> !REG_RD_REQ_OUT && !CMD_READY_OUT;
	endproperty
	a_rd_busy: assert property (p_rd_busy)
		else $error("register read overlaps new bytes");
	property p_len_step;
		$changed(STR_LEN_OUT) |-> STR_LEN_OUT == $past(STR_LEN_OUT) + 8'h01;
	endproperty
	a_len_step: assert property (p_len_step)
		else $error("string length moved by other than one");
	property p_sel_rng;
		{1'b0, SEL_START_OUT} + {1'b0, SEL_LEN_OUT} <= {1'b0, STR_LEN_OUT};
	endproperty
	a_sel_rng: assert property (p_sel_rng)
		else $error("selection beyond string end");
	property p_cmp_code;
		$changed(STATUS_OUT) && !$past(take) |-> STATUS_OUT <= 8'h02;
	endproperty
	a_cmp_code: assert property (p_cmp_code)
		else $error("compare status code invalid");
	property p_ready_back;
		$fell(CMD_READY_OUT) |-> ##[1:700] CMD_READY_OUT;
	endproperty
	a_ready_back: assert property (p_ready_back)
		else $error("interpreter stuck busy");
endmodule
bind pss_top pss_chk i_chk (.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN),
	.CMD_VALID_IN(CMD_VALID_IN), .CMD_READY_OUT(CMD_READY_OUT),
	.REGA_IS64_IN(REGA_IS64_IN), .REG_RD_REQ_OUT(REG_RD_REQ_OUT),
	.PTR_WR_OUT(PTR_WR_OUT), .PTR_WR_ADDR_OUT(PTR_WR_ADDR_OUT),
	.PTR_WR_DATA_OUT(PTR_WR_DATA_OUT), .STATUS_OUT(STATUS_OUT),
	.READ_HOLD_OUT(READ_HOLD_OUT), .READ_DONE_IN(READ_DONE_IN),
	.SEL_START_OUT(SEL_START_OUT), .SEL_LEN_OUT(SEL_LEN_OUT),
	.STR_LEN_OUT(STR_LEN_OUT));
